// [verilog/pin_change_pkg.sv]
package pin_change_pkg;

  // ==========================================================================
  // Register map, byte addresses on the AXI4-Lite bus.
  localparam logic [4:0] ADDR_PORT_A_PINS      = 5'h00;
  localparam logic [4:0] ADDR_PORT_B_PINS      = 5'h04;
  localparam logic [4:0] ADDR_PORT_A_CHANGE_EN = 5'h08;
  localparam logic [4:0] ADDR_PORT_B_CHANGE_EN = 5'h0C;
  localparam logic [4:0] ADDR_CORE_INT_CTRL    = 5'h10;

  // ==========================================================================
  // Implemented bits and reset values.
  localparam logic [7:0] PORT_A_EN_MASK     = 8'hEF;
  localparam logic [7:0] PORT_B_EN_MASK_BIG = 8'hF3;
  localparam logic [7:0] PORT_B_EN_MASK_SML = 8'h03;
  localparam logic [7:0] PORT_A_PIN5_MASK   = 8'h20;
  localparam logic [7:0] ENABLE_RESET       = 8'h00;

  // Core interrupt control layout: bit 3 is the enable, bit 0 the flag.
  localparam int CTRL_IRQ_EN_BIT = 3;
  localparam int CTRL_FLAG_BIT   = 0;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ==========================================================================
  // Port pin pair carried as one group.
  typedef struct packed {
    logic [7:0] portA;
    logic [7:0] portB;
  } port_pair_t;

endpackage : pin_change_pkg

// [verilog/port_pin_change_interrupt.sv]
// What this block does
// [R1] Enabled pins differing from the last-read latch set the shared change flag.
// [R2] Flag still sets with the interrupt enable clear; no interrupt is raised then.
// [R3] Power-on reset clears every change-enable bit.
// [R4] Software reads a port to reload the latch, then clears the flag.
// [R5] A port write followed by a flag clear also ends the mismatch.
// [R6] A persisting mismatch keeps setting the flag despite clears.
// [R7] The latch survives external-pin reset; the flag re-sets on a mismatch.
// [R8] A pin change during a port access may be missed.
// [R9] A pin change wakes the device from sleep when the enable is set.
// [R10] Port A enables at bits 7-6, 5 and 3-0, reset to zero.
// [R11] Port A enable bit 4 is absent and reads zero.
// [R12] Port A pin 5 detection is off while it serves as external reset.
// [R13] Port B enables at 7-4 and 1-0; 3-2 read zero; 7-4 on large variant.
// [R14] Pins are synchronised before comparison.
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps

module port_pin_change_interrupt
  import pin_change_pkg::*;
#(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  // Clock, resets and enable
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        extResetPulse,
  input  wire logic        clkEn,
  // AXI4-Lite write address and data
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Port pins and configuration
  input  wire port_pair_t  portPins,
  input  wire logic        portAPin5IsExtReset,
  // Events
  output logic             pinChangeIrq,
  output logic             sleepWake
);

  // ==========================================================================
  // State.
  port_pair_t  sync1_r, sync2_r, lastRead_r, lastRead_nxt;
  logic [7:0]  enA_r, enA_nxt, enB_r, enB_nxt;
  logic        flag_r, flag_nxt, irqEn_r, irqEn_nxt;
  logic        irq_r, irq_nxt, wake_r, wake_nxt;
  logic        awRdy_r, awRdy_nxt, wRdy_r, wRdy_nxt, bValid_r, bValid_nxt;
  logic        arRdy_r, arRdy_nxt, rValid_r, rValid_nxt;
  logic [1:0]  bResp_r, bResp_nxt, rResp_r, rResp_nxt;
  logic [31:0] rData_r, rData_nxt;
  logic [4:0]  awAddr_r, awAddr_nxt;
  logic [31:0] wData_r, wData_nxt;
  logic        awHave_r, awHave_nxt, wHave_r, wHave_nxt;

  function automatic logic addrKnown(input logic [4:0] a);
    if (a == ADDR_PORT_A_PINS) begin
      return 1'b1;
    end else if (a == ADDR_PORT_B_PINS) begin
      return 1'b1;
    end else if (a == ADDR_PORT_A_CHANGE_EN) begin
      return 1'b1;
    end else if (a == ADDR_PORT_B_CHANGE_EN) begin
      return 1'b1;
    end else if (a == ADDR_CORE_INT_CTRL) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction : addrKnown

  // ==========================================================================
  // Pin synchroniser; the first stage feeds only the second.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else if (clkEn) begin
      sync1_r <= portPins; // [R14]
      sync2_r <= sync1_r;
    end
  end

  // ==========================================================================
  // Mismatch detection.
  logic [7:0] effEnA, effEnB, bMask;
  logic       mismatch, doWrite, doRead, portAccess;
  logic [4:0] rdAddr;
  logic [31:0] wVal;

  always_comb begin
    bMask  = LARGE_PACKAGE ? PORT_B_EN_MASK_BIG : PORT_B_EN_MASK_SML;
    effEnA = enA_r & PORT_A_EN_MASK;
    if (portAPin5IsExtReset) begin
      effEnA = effEnA & ~PORT_A_PIN5_MASK; // [R12]
    end
    effEnB   = enB_r & bMask;
    mismatch = |((sync2_r.portA ^ lastRead_r.portA) & effEnA) |
               |((sync2_r.portB ^ lastRead_r.portB) & effEnB); // [R1]
  end

  // ==========================================================================
  // Bus and register next-state logic.
  always_comb begin
    awAddr_nxt = awAddr_r;
    wData_nxt  = wData_r;
    awHave_nxt = awHave_r;
    wHave_nxt  = wHave_r;
    awRdy_nxt  = awRdy_r;
    wRdy_nxt   = wRdy_r;
    bValid_nxt = bValid_r;
    bResp_nxt  = bResp_r;
    arRdy_nxt  = arRdy_r;
    rValid_nxt = rValid_r;
    rResp_nxt  = rResp_r;
    rData_nxt  = rData_r;
    enA_nxt    = enA_r;
    enB_nxt    = enB_r;
    irqEn_nxt  = irqEn_r;
    lastRead_nxt = lastRead_r;
    flag_nxt   = flag_r;
    doWrite    = 1'b0;
    doRead     = 1'b0;
    rdAddr     = s_axi_araddr;
    wVal       = wData_r;

    if (s_axi_awvalid && awRdy_r) begin
      awAddr_nxt = s_axi_awaddr;
      awHave_nxt = 1'b1;
      awRdy_nxt  = 1'b0;
    end
    if (s_axi_wvalid && wRdy_r) begin
      wData_nxt = s_axi_wdata;
      wHave_nxt = 1'b1;
      wRdy_nxt  = 1'b0;
    end
    if (awHave_r && wHave_r && !bValid_r) begin
      doWrite    = 1'b1;
      bValid_nxt = 1'b1;
      bResp_nxt  = addrKnown(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
      awHave_nxt = 1'b0;
      wHave_nxt  = 1'b0;
    end
    if (bValid_r && s_axi_bready) begin
      bValid_nxt = 1'b0;
      awRdy_nxt  = 1'b1;
      wRdy_nxt   = 1'b1;
    end

    if (s_axi_arvalid && arRdy_r) begin
      doRead     = 1'b1;
      arRdy_nxt  = 1'b0;
      rValid_nxt = 1'b1;
      rResp_nxt  = addrKnown(rdAddr) ? RESP_OKAY : RESP_SLVERR;
      rData_nxt  = '0;
      if (rdAddr == ADDR_PORT_A_PINS) begin
        rData_nxt[7:0] = sync2_r.portA;
      end else if (rdAddr == ADDR_PORT_B_PINS) begin
        rData_nxt[7:0] = sync2_r.portB & bMask;
      end else if (rdAddr == ADDR_PORT_A_CHANGE_EN) begin
        rData_nxt[7:0] = enA_r & PORT_A_EN_MASK; // [R11]
      end else if (rdAddr == ADDR_PORT_B_CHANGE_EN) begin
        rData_nxt[7:0] = enB_r & bMask; // [R13]
      end else if (rdAddr == ADDR_CORE_INT_CTRL) begin
        rData_nxt[CTRL_IRQ_EN_BIT] = irqEn_r;
        rData_nxt[CTRL_FLAG_BIT]   = flag_r;
      end
    end
    if (rValid_r && s_axi_rready) begin
      rValid_nxt = 1'b0;
      arRdy_nxt  = 1'b1;
    end

    // A port read reloads the latch; a port write with wstrb[0] set does too, so the
    // mismatch ends either way before software clears the flag.
    portAccess = 1'b0;
    if (doRead && (rdAddr == ADDR_PORT_A_PINS ||
                   rdAddr == ADDR_PORT_B_PINS)) begin
      portAccess = 1'b1; // [R4]
    end
    if (doWrite && s_axi_wstrb[0] && (awAddr_r == ADDR_PORT_A_PINS ||
                                      awAddr_r == ADDR_PORT_B_PINS)) begin
      portAccess = 1'b1; // [R5]
    end
    if (portAccess) begin
      lastRead_nxt = sync2_r;
    end

    if (doWrite && s_axi_wstrb[0]) begin
      if (awAddr_r == ADDR_PORT_A_CHANGE_EN) begin
        enA_nxt = wVal[7:0] & PORT_A_EN_MASK; // [R10] [R11]
      end else if (awAddr_r == ADDR_PORT_B_CHANGE_EN) begin
        enB_nxt = wVal[7:0] & bMask; // [R13]
      end else if (awAddr_r == ADDR_CORE_INT_CTRL) begin
        irqEn_nxt = wVal[CTRL_IRQ_EN_BIT];
        if (wVal[CTRL_FLAG_BIT]) begin
          flag_nxt = 1'b0;
        end
      end
    end
    // The set wins over a clear. During a port access the stale compare
    // is skipped, which may miss a change landing in that very cycle.
    if (mismatch && !portAccess) begin
      flag_nxt = 1'b1; // [R6] [R8] [R2]
    end
  end

  always_comb begin
    irq_nxt  = flag_r && irqEn_r; // [R2]
    wake_nxt = flag_r && irqEn_r; // [R9]
  end

  // ==========================================================================
  // The latch only sees power-on reset, never the external-pin reset.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lastRead_r <= '0;
    end else if (clkEn) begin
      lastRead_r <= lastRead_nxt; // [R7]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enA_r    <= ENABLE_RESET; // [R3]
      enB_r    <= ENABLE_RESET; // [R3]
      irqEn_r  <= 1'b0;
      flag_r   <= 1'b0;
      irq_r    <= 1'b0;
      wake_r   <= 1'b0;
      awRdy_r  <= 1'b1;
      wRdy_r   <= 1'b1;
      bValid_r <= 1'b0;
      bResp_r  <= RESP_OKAY;
      arRdy_r  <= 1'b1;
      rValid_r <= 1'b0;
      rResp_r  <= RESP_OKAY;
      rData_r  <= '0;
      awAddr_r <= '0;
      wData_r  <= '0;
      awHave_r <= 1'b0;
      wHave_r  <= 1'b0;
    end else if (clkEn) begin
      if (extResetPulse) begin
        enA_r   <= ENABLE_RESET;
        enB_r   <= ENABLE_RESET;
        irqEn_r <= 1'b0;
        flag_r  <= 1'b0;
        irq_r   <= 1'b0;
        wake_r  <= 1'b0;
      end else begin
        enA_r   <= enA_nxt;
        enB_r   <= enB_nxt;
        irqEn_r <= irqEn_nxt;
        flag_r  <= flag_nxt;
        irq_r   <= irq_nxt;
        wake_r  <= wake_nxt;
      end
      awRdy_r  <= awRdy_nxt;
      wRdy_r   <= wRdy_nxt;
      bValid_r <= bValid_nxt;
      bResp_r  <= bResp_nxt;
      arRdy_r  <= arRdy_nxt;
      rValid_r <= rValid_nxt;
      rResp_r  <= rResp_nxt;
      rData_r  <= rData_nxt;
      awAddr_r <= awAddr_nxt;
      wData_r  <= wData_nxt;
      awHave_r <= awHave_nxt;
      wHave_r  <= wHave_nxt;
    end
  end

  assign s_axi_awready = awRdy_r;
  assign s_axi_wready  = wRdy_r;
  assign s_axi_bvalid  = bValid_r;
  assign s_axi_bresp   = bResp_r;
  assign s_axi_arready = arRdy_r;
  assign s_axi_rvalid  = rValid_r;
  assign s_axi_rresp   = rResp_r;
  assign s_axi_rdata   = rData_r;
  assign pinChangeIrq  = irq_r;
  assign sleepWake     = wake_r;

endmodule : port_pin_change_interrupt

// [test/pin_source.sv]
`timescale 1ns/100ps
// ====================================================================
// Far-side pin drivers: each new level lands on a clock edge.
module pin_source
  import pin_change_pkg::*;
(
  // Clock
  input  wire logic       sys_clk,
  // Requested and driven levels
  input  wire port_pair_t target,
  output port_pair_t      portPins
);
  always_ff @(posedge sys_clk) begin
    portPins <= target;
  end
endmodule : pin_source

// [test/pin_change_assertions.sv]
`timescale 1ns/100ps
// ====================================================================
// Bus handshake and interrupt checks.
module pin_change_chk
  import pin_change_pkg::*;
(
  input wire logic sys_clk, rst_n, extResetPulse, clkEn,
  input wire logic s_axi_awready, s_axi_wready, s_axi_bvalid,
  input wire logic s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic s_axi_rvalid, s_axi_rready, pinChangeIrq, sleepWake
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_wake_irq: assert property (sleepWake == pinChangeIrq)
    else $error("wake differs from irq");
  chk_ar_answer: assert property (clkEn && s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  chk_aw_block: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken early");
  chk_ext_clear: assert property (extResetPulse && clkEn
    |=> ##1 !pinChangeIrq) else $error("irq after pin reset");
  chk_freeze_irq: assert property (!clkEn |=> $stable(pinChangeIrq))
    else $error("irq moved while frozen");
  chk_r_release: assert property (clkEn && s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid) else $error("read answer repeated");
  chk_b_release: assert property (clkEn && s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid ##0 s_axi_awready) else $error("write not closed");
  cover property (pinChangeIrq);
  cover property (!clkEn && pinChangeIrq);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule : pin_change_chk

bind port_pin_change_interrupt pin_change_chk chk (.sys_clk(sys_clk),
  .rst_n(rst_n), .extResetPulse(extResetPulse), .clkEn(clkEn),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .pinChangeIrq(pinChangeIrq), .sleepWake(sleepWake));

// [test/port_pin_change_interrupt_tb.sv]
`timescale 1ns/100ps
// ====================================================================
// Self-checking bench: register bus, pin changes, flag and wake.
module port_pin_change_interrupt_tb;
  import pin_change_pkg::*;
  logic sysClk = 0, rstN = 0, extRst = 0, clkEn = 1, a5Rst = 0;
  logic [4:0] awAddr = 0, arAddr = 0;
  logic [31:0] wData = 0, rData;
  logic awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
  logic awReady, wReady, bValid, arReady, rValid, irq, wake;
  logic [1:0] bResp, rResp;
  port_pair_t tgt = '0;
  port_pair_t pins;
  logic [33:0] expQ[$];
  logic [1:0] bQ[$];
  logic [7:0] rnd = 8'h34;
  int errCount = 0;
  int totalChecks = 0;
  always #5 sysClk = ~sysClk;
  pin_source far (.sys_clk(sysClk), .target(tgt), .portPins(pins));
  port_pin_change_interrupt #(.LARGE_PACKAGE(1'b1)) uut (
    .sys_clk(sysClk), .rst_n(rstN), .extResetPulse(extRst), .clkEn(clkEn),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .portPins(pins),
    .portAPin5IsExtReset(a5Rst), .pinChangeIrq(irq), .sleepWake(wake));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic [33:0] ok(input logic [7:0] v);
    return {RESP_OKAY, 24'h00_0000, v};
  endfunction : ok
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    totalChecks++;
    if (s !== e) begin
      errCount++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    int n;
    bQ.push_back(er);
    @(posedge sysClk);
    awAddr <= a; wData <= d; awValid <= 1; wValid <= 1; bReady <= 1;
    for (n = 0; n < 40 && !(bValid && bReady); n++) begin
      @(posedge sysClk);
      if (awReady) awValid <= 0;
      if (wReady) wValid <= 0;
    end
    bReady <= 0;
    if (n == 40) begin errCount++; end_sim; end
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [33:0] e);
    int n;
    expQ.push_back(e);
    @(posedge sysClk);
    arAddr <= a; arValid <= 1; rReady <= 1;
    for (n = 0; n < 40 && !(rValid && rReady); n++) begin
      @(posedge sysClk);
      if (arReady) arValid <= 0;
    end
    rReady <= 0;
    if (n == 40) begin errCount++; end_sim; end
  endtask : rd
  // Two sync stages, the flag and the irq register all lie in this wait.
  task automatic settle;
    repeat (6) @(posedge sysClk);
  endtask : settle
  always @(posedge sysClk) if (rValid && rReady) begin
    chk({rResp, rData}, expQ.pop_front());
  end
  // Every write answer is held against the response noted by wr.
  always @(posedge sysClk) if (bValid && bReady) begin
    chk({32'h0000_0000, bResp}, {32'h0000_0000, bQ.pop_front()});
  end
  initial begin
    repeat (8) @(posedge sysClk);
    rstN <= 1;
    rd(ADDR_PORT_A_CHANGE_EN, ok(ENABLE_RESET));
    rd(ADDR_PORT_B_CHANGE_EN, ok(ENABLE_RESET));
    rd(ADDR_CORE_INT_CTRL, ok(8'h00));
    rd(5'h14, {RESP_SLVERR, 32'h0000_0000});
    wr(5'h14, 32'h0000_00FF, RESP_SLVERR);
    wr(ADDR_PORT_A_CHANGE_EN, 32'h0000_00FF);
    wr(ADDR_PORT_B_CHANGE_EN, 32'h0000_00FF);
    rd(ADDR_PORT_A_CHANGE_EN, ok(PORT_A_EN_MASK));
    rd(ADDR_PORT_B_CHANGE_EN, ok(PORT_B_EN_MASK_BIG));
    $display("test 1 done");
    rnd = lfsr(rnd);
    tgt <= {rnd | 8'h01, lfsr(rnd)};
    settle;
    rd(ADDR_PORT_A_PINS, ok(rnd | 8'h01));
    tgt <= tgt ^ 16'h0100;
    settle;
    chk({33'h0, irq}, 34'h0);
    rd(ADDR_CORE_INT_CTRL, ok(8'h01));
    wr(ADDR_CORE_INT_CTRL, 32'h0000_0009);
    settle;
    chk({33'h0, irq}, 34'h1);
    chk({33'h0, wake}, 34'h1);
    clkEn <= 0;
    repeat (3) @(posedge sysClk);
    clkEn <= 1;
    rd(ADDR_PORT_A_PINS, ok(rnd & 8'hFE));
    wr(ADDR_CORE_INT_CTRL, 32'h0000_0009);
    settle;
    chk({33'h0, irq}, 34'h0);
    $display("test 2 done");
    tgt <= tgt ^ 16'h0100;
    settle;
    rd(ADDR_CORE_INT_CTRL, ok(8'h09));
    wr(ADDR_PORT_B_PINS, 32'h0000_0000);
    wr(ADDR_CORE_INT_CTRL, 32'h0000_0009);
    settle;
    rd(ADDR_CORE_INT_CTRL, ok(8'h08));
    $display("test 3 done");
    a5Rst <= 1;
    tgt <= tgt ^ 16'h2000;
    settle;
    rd(ADDR_CORE_INT_CTRL, ok(8'h08));
    extRst <= 1;
    @(posedge sysClk);
    extRst <= 0;
    wr(ADDR_PORT_A_CHANGE_EN, 32'h0000_00EF);
    settle;
    rd(ADDR_CORE_INT_CTRL, ok(8'h00));
    // Unmasking pin 5 exposes the mismatch the kept latch still holds.
    a5Rst <= 0;
    settle;
    rd(ADDR_CORE_INT_CTRL, ok(8'h01));
    $display("test 4 done");
    end_sim;
  end
endmodule : port_pin_change_interrupt_tb
